/* verilog/psst_consts.svh */
// Register map, field positions, reset values and counts of the sleep timer
// What this block does
// - Settle phase before cycle end, count times 0.5ms
// - Settle count bits 7:4, unit 16 ticks
// - Sleep length decrements to zero, cycle ends
// - Sleep length 23 bits over three registers
// - Sleep length decrements once per crystal tick
// - Hold bit ignores counts, waits for host
// - 24-bit free tick counter on crystal clock
// - Free tick cleared only by reset
// - Free tick shown low, middle, high byte
// - Command bit starts cycle, self clears after
// - Completion sets done flag and interrupt unless a done clear write of 1 is still held
`ifndef PSST_CONSTS_SVH
`define PSST_CONSTS_SVH

// Register indices in the processor register space
`define PSST_ADDR_CTRL 4'h0
`define PSST_ADDR_SETTLE 4'h1
`define PSST_ADDR_LEN_LOW 4'h2
`define PSST_ADDR_LEN_MID 4'h3
`define PSST_ADDR_LEN_HIGH 4'h4
`define PSST_ADDR_TICK_LOW 4'h5
`define PSST_ADDR_TICK_MID 4'h6
`define PSST_ADDR_TICK_HIGH 4'h7

// Field positions
`define PSST_CTRL_CMD_BIT 4
`define PSST_CTRL_DONE_BIT 0
`define PSST_HOLD_BIT 7

// Reset values
`define PSST_SETTLE_RST 4'h0
`define PSST_LEN_RST 23'h000000
`define PSST_TICK_RST 24'h000000
`define PSST_RDATA_RST 8'h00

// Crystal ticks per settle unit (16 x 31.25 us = 0.5 ms)
`define PSST_SETTLE_UNIT_LOG2 4

`endif

/* verilog/psst_pkg.sv */
// Types shared by the sleep timer modules
package psst_pkg;

  // Register port request from the embedded processor
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } psst_reg_req_s;

  // Power-down sequencer states
  typedef enum logic [2:0] {
    PSST_IDLE,
    PSST_SLEEP,
    PSST_HOLD,
    PSST_SETTLE,
    PSST_FINISH
  } psst_state_e;

endpackage : psst_pkg

/* verilog/psst_tick_sync.sv */
// Synchroniser and rising-edge tick for the low-speed crystal clock
`timescale 1ns/10ps
module psst_tick_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic tick
);

  logic meta;
  logic sync;
  logic sync_d;
  logic next_tick;

  // Edge of the synchronised level, one cycle per crystal period
  always_comb begin
    next_tick = sync & ~sync_d;
  end

  // Two-stage synchroniser then edge history
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      sync_d <= 1'b0;
      tick <= 1'b0;
    end else begin
      meta <= async_in;
      sync <= meta;
      sync_d <= sync;
      tick <= next_tick;
    end
  end

endmodule : psst_tick_sync

/* verilog/psst_free_tick.sv */
// Free-running 24-bit crystal tick counter
`include "psst_consts.svh"
`timescale 1ns/10ps
module psst_free_tick (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  output logic [23:0] count
);

  logic [23:0] next_count;

  // Advance once per crystal period, wrap at the top
  always_comb begin
    next_count = count;
    if (tick) begin
      next_count = count + 24'h000001;
    end
  end

  // Only the reset input clears the count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= `PSST_TICK_RST;
    end else begin
      count <= next_count;
    end
  end

endmodule : psst_free_tick

/* verilog/psst_sleep_timer.sv */
// Power-down sleep timer: registers, sleep and settle counters, sequencer
`include "psst_consts.svh"
`timescale 1ns/10ps
module psst_sleep_timer (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic LOW_SPEED_CRYSTAL_CLOCK,
  input wire psst_pkg::psst_reg_req_s REG_REQ,
  input wire logic CARD_POWER_DOWN_REQUEST,
  input wire logic DISABLE_POWER_DOWN,
  output logic [7:0] REG_RDATA,
  output logic POWER_DOWN_DONE_IRQ,
  output logic MAIN_CLOCK_INPUT_BUF_EN,
  output logic SLEEPING
);

  logic tick;
  logic [23:0] free_running_tick;

  // Register state
  logic [3:0] power_up_settle_count;
  logic [22:0] sleep_length_count;
  logic hold_asleep_until_host;
  logic power_down_command;
  logic power_down_done_flag;
  logic done_clear_hold;
  logic [7:0] next_rdata;
  logic [3:0] next_settle;
  logic [22:0] next_length;
  logic next_hold;
  logic next_command;
  logic next_done;
  logic next_clear_hold;

  // Sequencer state
  psst_pkg::psst_state_e state;
  psst_pkg::psst_state_e next_state;
  logic [7:0] settle_left;
  logic [7:0] next_settle_left;
  logic next_buf_en;
  logic next_sleeping;
  logic next_irq;

  // Decoded writes
  logic wr_ctrl;
  logic wr_settle;
  logic wr_low;
  logic wr_mid;
  logic wr_high;
  logic finish;
  logic length_dec;

  psst_tick_sync u_tick_sync (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .async_in(LOW_SPEED_CRYSTAL_CLOCK),
    .tick(tick)
  );

  psst_free_tick u_free_tick (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .tick(tick),
    .count(free_running_tick)
  );

  // Address decode of processor writes
  always_comb begin
    wr_ctrl = REG_REQ.wr && (REG_REQ.addr == `PSST_ADDR_CTRL);
    wr_settle = REG_REQ.wr && (REG_REQ.addr == `PSST_ADDR_SETTLE);
    wr_low = REG_REQ.wr && (REG_REQ.addr == `PSST_ADDR_LEN_LOW);
    wr_mid = REG_REQ.wr && (REG_REQ.addr == `PSST_ADDR_LEN_MID);
    wr_high = REG_REQ.wr && (REG_REQ.addr == `PSST_ADDR_LEN_HIGH);
  end

  // Sequencer next state and counters
  always_comb begin
    next_state = state;
    next_settle_left = settle_left;
    next_buf_en = 1'b1;
    next_sleeping = 1'b0;
    finish = 1'b0;
    length_dec = 1'b0;
    case (state)
      psst_pkg::PSST_IDLE: begin
        if (power_down_command) begin
          next_sleeping = 1'b1;
          next_buf_en = 1'b0;
          if (hold_asleep_until_host) begin
            next_state = psst_pkg::PSST_HOLD;
          end else begin
            next_state = psst_pkg::PSST_SLEEP;
          end
        end
      end
      psst_pkg::PSST_SLEEP: begin
        next_sleeping = 1'b1;
        next_buf_en = 1'b0;
        if (sleep_length_count == 23'h000000) begin
          // Settle length in ticks: count x 16
          next_settle_left = {power_up_settle_count, 4'h0};
          next_state = psst_pkg::PSST_SETTLE;
          next_buf_en = 1'b1;
        end else if (tick) begin
          length_dec = 1'b1;
        end
      end
      psst_pkg::PSST_HOLD: begin
        next_sleeping = 1'b1;
        next_buf_en = 1'b0;
        // Counts ignored; only the host releases the device
        if (!CARD_POWER_DOWN_REQUEST || DISABLE_POWER_DOWN) begin
          next_state = psst_pkg::PSST_FINISH;
          next_buf_en = 1'b1;
        end
      end
      psst_pkg::PSST_SETTLE: begin
        next_sleeping = 1'b1;
        if (settle_left == 8'h00) begin
          next_state = psst_pkg::PSST_FINISH;
        end else if (tick) begin
          next_settle_left = settle_left - 8'h01;
        end
      end
      psst_pkg::PSST_FINISH: begin
        finish = 1'b1;
        next_state = psst_pkg::PSST_IDLE;
      end
      default: begin
        next_state = psst_pkg::PSST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state <= psst_pkg::PSST_IDLE;
      settle_left <= 8'h00;
      MAIN_CLOCK_INPUT_BUF_EN <= 1'b1;
      SLEEPING <= 1'b0;
    end else begin
      state <= next_state;
      settle_left <= next_settle_left;
      MAIN_CLOCK_INPUT_BUF_EN <= next_buf_en;
      SLEEPING <= next_sleeping;
    end
  end

  // Register file next values
  always_comb begin
    next_settle = power_up_settle_count;
    next_length = sleep_length_count;
    next_hold = hold_asleep_until_host;
    next_command = power_down_command;
    next_done = power_down_done_flag;
    next_clear_hold = done_clear_hold;
    // Live decrement of the loaded length
    if (length_dec) begin
      next_length = sleep_length_count - 23'h000001;
    end
    // Upper nibble only; low nibble is reserved
    if (wr_settle) begin
      next_settle = REG_REQ.wdata[7:4];
    end
    // Processor writes take priority over the decrement
    if (wr_low) begin
      next_length[7:0] = REG_REQ.wdata;
    end
    if (wr_mid) begin
      next_length[15:8] = REG_REQ.wdata;
    end
    if (wr_high) begin
      next_length[22:16] = REG_REQ.wdata[6:0];
      next_hold = REG_REQ.wdata[`PSST_HOLD_BIT];
    end
    // Command set by writing 1, cleared by completion
    if (wr_ctrl && REG_REQ.wdata[`PSST_CTRL_CMD_BIT]) begin
      next_command = 1'b1;
    end
    if (finish) begin
      next_command = 1'b0;
    end
    // Done flag: write 1 clears and holds, write 0 releases
    if (wr_ctrl) begin
      next_clear_hold = REG_REQ.wdata[`PSST_CTRL_DONE_BIT];
    end
    if (next_clear_hold) begin
      next_done = 1'b0;
    end
    if (finish && !(done_clear_hold && next_clear_hold)) begin
      next_done = 1'b1;
    end
  end

  // Read mux, answered one cycle after the read strobe
  always_comb begin
    next_rdata = `PSST_RDATA_RST;
    if (REG_REQ.rd) begin
      case (REG_REQ.addr)
        `PSST_ADDR_CTRL: begin
          next_rdata[`PSST_CTRL_CMD_BIT] = power_down_command;
          next_rdata[`PSST_CTRL_DONE_BIT] = power_down_done_flag;
        end
        `PSST_ADDR_SETTLE: next_rdata = {power_up_settle_count, 4'h0};
        `PSST_ADDR_LEN_LOW: next_rdata = sleep_length_count[7:0];
        `PSST_ADDR_LEN_MID: next_rdata = sleep_length_count[15:8];
        `PSST_ADDR_LEN_HIGH: next_rdata = {hold_asleep_until_host, sleep_length_count[22:16]};
        `PSST_ADDR_TICK_LOW: next_rdata = free_running_tick[7:0];
        `PSST_ADDR_TICK_MID: next_rdata = free_running_tick[15:8];
        `PSST_ADDR_TICK_HIGH: next_rdata = free_running_tick[23:16];
        default: next_rdata = `PSST_RDATA_RST;
      endcase
    end
  end

  // Interrupt follows the done flag
  always_comb begin
    next_irq = next_done;
  end

  // Register file registers
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      power_up_settle_count <= `PSST_SETTLE_RST;
      sleep_length_count <= `PSST_LEN_RST;
      hold_asleep_until_host <= 1'b0;
      power_down_command <= 1'b0;
      power_down_done_flag <= 1'b0;
      done_clear_hold <= 1'b0;
      REG_RDATA <= `PSST_RDATA_RST;
      POWER_DOWN_DONE_IRQ <= 1'b0;
    end else begin
      power_up_settle_count <= next_settle;
      sleep_length_count <= next_length;
      hold_asleep_until_host <= next_hold;
      power_down_command <= next_command;
      power_down_done_flag <= next_done;
      done_clear_hold <= next_clear_hold;
      REG_RDATA <= next_rdata;
      POWER_DOWN_DONE_IRQ <= next_irq;
    end
  end

endmodule : psst_sleep_timer

/* test/psst_sleep_timer_properties.sv */
// Port checker for the sleep timer
`timescale 1ns/10ps
module psst_sleep_timer_properties (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic LOW_SPEED_CRYSTAL_CLOCK,
  input wire psst_pkg::psst_reg_req_s REG_REQ,
  input wire logic CARD_POWER_DOWN_REQUEST,
  input wire logic DISABLE_POWER_DOWN,
  input wire logic [7:0] REG_RDATA,
  input wire logic POWER_DOWN_DONE_IRQ,
  input wire logic MAIN_CLOCK_INPUT_BUF_EN,
  input wire logic SLEEPING
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  // Reset leaves idle outputs
  a_reset_values: assert property (disable iff (1'b0) !RST_N |=> REG_RDATA == 8'h00
    && !POWER_DOWN_DONE_IRQ && MAIN_CLOCK_INPUT_BUF_EN && !SLEEPING) else $error("reset values wrong");
  // Read data only follows a read
  a_rdata_idle: assert property (!REG_REQ.rd |=> REG_RDATA == 8'h00) else $error("stray read data");
  a_unmapped_read: assert property (REG_REQ.rd && REG_REQ.addr[3] |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_settle_low_read: assert property (REG_REQ.rd && REG_REQ.addr == 4'h1 |=> REG_RDATA[3:0] == 4'h0)
    else $error("settle low bits not zero");
  // Command from idle starts the cycle two edges later
  a_cmd_start: assert property (REG_REQ.wr && REG_REQ.addr == 4'h0 && REG_REQ.wdata[4] && !SLEEPING
    && !$past(SLEEPING) && !$past(SLEEPING, 2) |-> ##2 SLEEPING) else $error("cycle did not start");
  a_buf_gate: assert property ($fell(MAIN_CLOCK_INPUT_BUF_EN) |-> SLEEPING)
    else $error("buffer off outside sleep");
  a_irq_at_end: assert property ($rose(POWER_DOWN_DONE_IRQ) |-> $past(SLEEPING)
    || $past(SLEEPING, 2) || $past(SLEEPING, 3)) else $error("done without cycle");
  a_irq_holds: assert property (POWER_DOWN_DONE_IRQ && !(REG_REQ.wr && REG_REQ.addr == 4'h0
    && REG_REQ.wdata[0]) |=> POWER_DOWN_DONE_IRQ) else $error("done dropped");
endmodule : psst_sleep_timer_properties

bind psst_sleep_timer psst_sleep_timer_properties chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .LOW_SPEED_CRYSTAL_CLOCK(LOW_SPEED_CRYSTAL_CLOCK), .REG_REQ(REG_REQ),
  .CARD_POWER_DOWN_REQUEST(CARD_POWER_DOWN_REQUEST), .DISABLE_POWER_DOWN(DISABLE_POWER_DOWN),
  .REG_RDATA(REG_RDATA), .POWER_DOWN_DONE_IRQ(POWER_DOWN_DONE_IRQ),
  .MAIN_CLOCK_INPUT_BUF_EN(MAIN_CLOCK_INPUT_BUF_EN), .SLEEPING(SLEEPING));

/* test/psst_xtal_model.sv */
// Low-speed crystal model feeding the timer
`timescale 1ns/10ps
module psst_xtal_model (
  input wire logic en,
  output logic xtal,
  output logic [23:0] rises
);
  initial xtal = 1'b0;
  initial rises = 24'h000000;
  // Oscillates off the system clock grid, parked low when off
  always begin
    #412;
    xtal = en ? ~xtal : 1'b0;
  end
  // Counts rises handed to the timer
  always @(posedge xtal) rises <= rises + 24'h000001;
endmodule : psst_xtal_model

/* test/test_power_down_sleep_timer.sv */
// Register-level test of the sleep timer
`timescale 1ns/10ps
module test_power_down_sleep_timer;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic xtal_en = 1'b0;
  logic xtal;
  logic [23:0] rises;
  psst_pkg::psst_reg_req_s req = '0;
  logic pd_req = 1'b1;
  logic pd_dis = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic buf_en;
  logic sleeping;
  logic [23:0] start;
  int bad_count = 0;
  int n_checks = 0;
  // System clock
  always #20 clk = ~clk;
  psst_xtal_model psst_xtal_model_inst (.en(xtal_en), .xtal(xtal), .rises(rises));
  psst_sleep_timer psst_sleep_timer_inst (.SYS_CLK(clk), .RST_N(rst_n), .LOW_SPEED_CRYSTAL_CLOCK(xtal),
    .REG_REQ(req), .CARD_POWER_DOWN_REQUEST(pd_req), .DISABLE_POWER_DOWN(pd_dis), .REG_RDATA(rdata),
    .POWER_DOWN_DONE_IRQ(irq), .MAIN_CLOCK_INPUT_BUF_EN(buf_en), .SLEEPING(sleeping));
  task summarize;
    if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    req = {1'b1, 1'b0, a, d};
    @(negedge clk);
    req = '0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] exp);
    @(negedge clk);
    req = {1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    req = '0;
    check($sformatf("reg%0h", a), {16'h0000, rdata}, {16'h0000, exp});
  endtask : rd
  task wait_irq;
    for (int i = 0; i < 2000 && irq !== 1'b1; i++) @(negedge clk);
    if (irq !== 1'b1) begin
      bad_count++;
      summarize();
    end
  endtask : wait_irq
  // Main sequence
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    for (int a = 0; a < 9; a++) rd(a[3:0], 8'h00);
    wr(4'h1, 8'h20);
    wr(4'h2, 8'h03);
    rd(4'h1, 8'h20);
    rd(4'h2, 8'h03);
    xtal_en = 1'b1;
    @(posedge xtal);
    repeat (8) @(negedge clk);
    start = rises;
    wr(4'h0, 8'h10);
    wait_irq();
    check("ticks", rises - start, 24'h000023);
    rd(4'h0, 8'h01);
    rd(4'h2, 8'h00);
    wr(4'h0, 8'h01);
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h00);
    @(posedge xtal);
    repeat (6) @(negedge clk);
    rd(4'h5, rises[7:0]);
    rd(4'h6, rises[15:8]);
    rd(4'h7, rises[23:16]);
    // Hold mode, released by each host level
    for (int i = 0; i < 2; i++) begin
      wr(4'h4, 8'h80);
      wr(4'h0, 8'h10);
      repeat (30) @(posedge xtal);
      @(negedge clk);
      check("hold", {22'h000000, irq, sleeping}, 24'h000001);
      check("buf off", {23'h000000, buf_en}, 24'h000000);
      if (i == 0) pd_req = 1'b0;
      else pd_dis = 1'b1;
      wait_irq();
      repeat (8) @(negedge clk);
      check("release", {22'h000000, irq, sleeping}, 24'h000002);
      check("buf on", {23'h000000, buf_en}, 24'h000001);
      pd_req = 1'b1;
      pd_dis = 1'b0;
      wr(4'h0, 8'h01);
      wr(4'h0, 8'h00);
    end
    // Only the reset clears the free tick
    xtal_en = 1'b0;
    // Let the crystal park low so no false edge follows reset
    repeat (12) @(negedge clk);
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    for (int a = 5; a < 8; a++) rd(a[3:0], 8'h00);
    summarize();
  end
endmodule : test_power_down_sleep_timer
